// ==== rtl/serial_port_pkg.sv ====
// constants, modes and states shared by the serial cpu port files
// assumes nothing beyond a tool that reads sv packages
package serial_port_pkg;

   // ----------------------------------------------------------------
   // port modes and boot sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_BOOT} mode_t;
   typedef enum logic [1:0] {BOOT_IDLE, BOOT_CMD, BOOT_DATA, BOOT_FIN} boot_state_t;

   // ----------------------------------------------------------------
   // slave frame layout: command byte, pad byte, data word
   // ----------------------------------------------------------------
   localparam int unsigned CMD_BITS = 8;
   localparam int unsigned PAD_BITS = 8;
   localparam int unsigned DATA_BITS = 32;
   localparam int unsigned ADDR_BITS = 7;
   localparam logic [5:0] CMD_DONE_CNT = 6'h08;
   localparam logic [5:0] DATA_FIRST_CNT = 6'h10;
   localparam logic [5:0] FRAME_CNT = 6'h30;
   localparam int unsigned CMD_WRITE_BIT = 7;

   // ----------------------------------------------------------------
   // boot straps and boot fetch
   // ----------------------------------------------------------------
   localparam int unsigned STRAP_W = 2;
   localparam logic [1:0] BOOT_STRAP = 2'h1;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam logic [23:0] BOOT_ADDR = 24'h000000;
   localparam logic [5:0] WORD_BITS = 6'h20;

   // ----------------------------------------------------------------
   // serial clock: half period in clk cycles, minus one
   // ----------------------------------------------------------------
   localparam logic [7:0] DEF_DIV = 8'h03;
   localparam logic [7:0] MIN_DIV = 8'h02;

endpackage

// ==== rtl/sync2.sv ====
// two flip-flop synchroniser for levels arriving from another domain
// assumes the input is a level that stays for several clk cycles
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= RST;
         sync_out <= RST;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ==== rtl/serial_shift_engine.sv ====
// clock-domain shift engine that makes the serial clock by division
// assumes miso is already synchronised; div of at least two is enforced
`timescale 1ns/1ps
module serial_shift_engine (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // request
   input wire logic start,
   input wire logic [5:0] nbits,
   input wire logic [31:0] wdata,
   input wire logic [7:0] div,
   // answer
   output logic [31:0] rdata,
   output logic busy,
   output logic done,
   // serial lines
   input wire logic miso,
   output logic sclk_q,
   output logic mosi_q
);

   logic [7:0] div_cnt_q;
   logic [5:0] bit_cnt_q;
   logic [31:0] shreg_q;
   logic [7:0] div_eff;
   logic [5:0] shift_amt;
   logic [31:0] aligned;

   // sampling at the falling transition hides the two-cycle miso sync delay
   assign div_eff = (div < serial_port_pkg::MIN_DIV) ? serial_port_pkg::MIN_DIV : div;
   assign shift_amt = serial_port_pkg::WORD_BITS - nbits;
   assign aligned = wdata << shift_amt;

   // mode 0 shifting: clock idles low, msb first
   always_ff @(posedge clk) begin
      if (srst) begin
         busy <= 1'b0;
         done <= 1'b0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         div_cnt_q <= 8'h00;
         bit_cnt_q <= 6'h00;
         shreg_q <= 32'h00000000;
         rdata <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (start && nbits != 6'h00) begin
               busy <= 1'b1;
               div_cnt_q <= 8'h00;
               bit_cnt_q <= nbits;
               shreg_q <= aligned;
               mosi_q <= aligned[31];
               rdata <= 32'h00000000;
            end
         end else if (div_cnt_q == div_eff) begin
            div_cnt_q <= 8'h00;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
               rdata <= {rdata[30:0], miso};
               shreg_q <= {shreg_q[30:0], 1'b0};
               mosi_q <= shreg_q[30];
               bit_cnt_q <= bit_cnt_q - 6'h01;
               if (bit_cnt_q == 6'h01) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
         end
      end
   end

endmodule

// ==== rtl/serial_cpu_port_mode_ctrl.sv ====
// serial cpu port: slave register access, programmable master, boot fetch
// assumes straps steady at reset; slave clock stops while select is high
`timescale 1ns/1ps
module serial_cpu_port_mode_ctrl #(
   parameter int unsigned BOOT_WORDS = 256,
   parameter logic [7:0] BOOT_DIV = serial_port_pkg::DEF_DIV
) (
   // clocks and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic slave_sclk,
   // serial clock pin
   output logic sclk_o,
   output logic sclk_oe,
   // serial data pins
   input wire logic serial_port_data_in,
   output logic data_out_o,
   output logic data_out_oe,
   // select pin
   input wire logic serial_port_select_n_i,
   output logic serial_port_select_n_o,
   output logic serial_port_select_n_oe,
   // mode control
   input wire logic [1:0] boot_config_straps,
   input wire logic master_enable,
   output serial_port_pkg::mode_t port_mode,
   // internal register port, slave side
   output logic [6:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [31:0] reg_rdata,
   // master command port
   input wire logic mst_start,
   input wire logic [5:0] mst_nbits,
   input wire logic [31:0] mst_wdata,
   input wire logic [7:0] mst_div,
   input wire logic mst_keep_select,
   output logic mst_busy,
   output logic mst_done,
   output logic [31:0] mst_rdata,
   // boot image stream
   output logic [31:0] boot_word,
   output logic boot_word_valid,
   output logic boot_done
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   serial_port_pkg::mode_t mode_q;
   serial_port_pkg::boot_state_t boot_st_q;
   logic [1:0] strap_wait_q;
   logic strap_taken_q;
   logic cs_s, cs_prev_q, di_s, cmdd_s, cmdd_prev_q;
   logic [1:0] straps_s;
   logic cs_rise, cmd_rise;
   logic re_prev_q;
   logic [31:0] rd_hold_q;
   logic slv_fresh_q, slv_cmd_done_q, slv_oe_q, slv_do_q;
   logic [5:0] slv_cnt_q;
   logic [7:0] slv_cmd_q;
   logic [31:0] slv_wr_q;
   logic [5:0] slv_idx;
   logic mst_go_q, mst_keep_q;
   logic [5:0] mst_nb_q;
   logic [31:0] mst_wd_q;
   logic boot_go_q;
   logic [5:0] boot_nb_q;
   logic [31:0] boot_wd_q;
   logic [15:0] boot_idx_q;
   logic eng_start, eng_done, eng_mosi, eng_sclk;
   logic [5:0] eng_nbits;
   logic [31:0] eng_wdata, eng_rdata;
   logic [7:0] eng_div;
   logic in_slave, in_master, in_boot;

   // ----------------------------------------------------------------
   // crossings into the clk domain
   // ----------------------------------------------------------------
   sync2 #(.W(1), .RST(1'b1)) u_sync_cs (
      .clk(clk),
      .srst(srst),
      .async_in(serial_port_select_n_i),
      .sync_out(cs_s)
   );

   sync2 #(.W(4), .RST(4'h0)) u_sync_misc (
      .clk(clk),
      .srst(srst),
      .async_in({boot_config_straps, serial_port_data_in, slv_cmd_done_q}),
      .sync_out({straps_s, di_s, cmdd_s})
   );

   assign cs_rise = cs_s & ~cs_prev_q;
   assign cmd_rise = cmdd_s & ~cmdd_prev_q;
   assign in_slave = (mode_q == serial_port_pkg::MODE_SLAVE);
   assign in_master = (mode_q == serial_port_pkg::MODE_MASTER);
   assign in_boot = (mode_q == serial_port_pkg::MODE_BOOT);

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   // straps are caught only once the synchroniser holds real pin values
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= serial_port_pkg::MODE_SLAVE;
         strap_wait_q <= 2'h0;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_wait_q <= strap_wait_q + 2'h1;
         if (strap_wait_q == serial_port_pkg::STRAP_SETTLE) begin
            strap_taken_q <= 1'b1;
            if (straps_s == serial_port_pkg::BOOT_STRAP) begin
               mode_q <= serial_port_pkg::MODE_BOOT;
            end else if (master_enable) begin
               mode_q <= serial_port_pkg::MODE_MASTER;
            end else begin
               mode_q <= serial_port_pkg::MODE_SLAVE;
            end
         end
      end else if (in_boot) begin
         if (boot_done) begin
            mode_q <= master_enable ? serial_port_pkg::MODE_MASTER
                                    : serial_port_pkg::MODE_SLAVE;
         end
      end else if (in_slave && master_enable && cs_s) begin
         mode_q <= serial_port_pkg::MODE_MASTER;
      end else if (in_master && !master_enable && !mst_busy && !mst_keep_q) begin
         mode_q <= serial_port_pkg::MODE_SLAVE;
      end
   end

   // pin roles follow the mode, changed only between accesses
   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_oe <= 1'b0;
         serial_port_select_n_oe <= 1'b0;
      end else begin
         sclk_oe <= !in_slave;
         serial_port_select_n_oe <= !in_slave;
      end
   end

   assign port_mode = mode_q;

   // ----------------------------------------------------------------
   // slave link logic on the external master's clock
   // ----------------------------------------------------------------
   // select high re-arms the frame but keeps the captured bits for the clk side
   always_ff @(posedge slave_sclk or posedge serial_port_select_n_i) begin
      if (serial_port_select_n_i) begin
         slv_fresh_q <= 1'b1;
         slv_cmd_done_q <= 1'b0;
      end else begin
         slv_fresh_q <= 1'b0;
         if (slv_cnt_q == serial_port_pkg::CMD_DONE_CNT - 6'h01 && !slv_fresh_q) begin
            slv_cmd_done_q <= 1'b1;
         end
      end
   end

   // bit counter and shift registers; data-in sampled on rising clock
   always_ff @(posedge slave_sclk) begin
      if (slv_fresh_q) begin
         slv_cnt_q <= 6'h01;
         slv_cmd_q <= {slv_cmd_q[6:0], serial_port_data_in};
      end else begin
         if (slv_cnt_q != serial_port_pkg::FRAME_CNT) begin
            slv_cnt_q <= slv_cnt_q + 6'h01;
         end
         if (slv_cnt_q < serial_port_pkg::CMD_DONE_CNT) begin
            slv_cmd_q <= {slv_cmd_q[6:0], serial_port_data_in};
         end else if (slv_cnt_q >= serial_port_pkg::DATA_FIRST_CNT) begin
            slv_wr_q <= {slv_wr_q[30:0], serial_port_data_in};
         end
      end
   end

   assign slv_idx = serial_port_pkg::FRAME_CNT - 6'h01 - slv_cnt_q;

   // response bits change on the falling clock; line floats when deselected
   always_ff @(negedge slave_sclk or posedge serial_port_select_n_i) begin
      if (serial_port_select_n_i) begin
         slv_oe_q <= 1'b0;
         slv_do_q <= 1'b0;
      end else begin
         slv_oe_q <= 1'b1;
         if (slv_cnt_q >= serial_port_pkg::DATA_FIRST_CNT
             && slv_cnt_q != serial_port_pkg::FRAME_CNT
             && !slv_cmd_q[serial_port_pkg::CMD_WRITE_BIT]) begin
            slv_do_q <= rd_hold_q[slv_idx[4:0]];
         end else begin
            slv_do_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // slave register access in the clk domain
   // ----------------------------------------------------------------
   // the pad byte gives the read time to land before data shifts out
   always_ff @(posedge clk) begin
      if (srst) begin
         cs_prev_q <= 1'b1;
         cmdd_prev_q <= 1'b0;
         re_prev_q <= 1'b0;
         reg_re <= 1'b0;
         reg_we <= 1'b0;
         reg_addr <= 7'h00;
         reg_wdata <= 32'h00000000;
         rd_hold_q <= 32'h00000000;
      end else begin
         cs_prev_q <= cs_s;
         cmdd_prev_q <= cmdd_s;
         re_prev_q <= reg_re;
         reg_re <= 1'b0;
         reg_we <= 1'b0;
         if (re_prev_q) begin
            rd_hold_q <= reg_rdata;
         end
         if (in_slave && cmd_rise && !slv_cmd_q[serial_port_pkg::CMD_WRITE_BIT]) begin
            reg_re <= 1'b1;
            reg_addr <= slv_cmd_q[6:0];
         end else if (in_slave && cs_rise && slv_cnt_q == serial_port_pkg::FRAME_CNT
                      && slv_cmd_q[serial_port_pkg::CMD_WRITE_BIT]) begin
            reg_we <= 1'b1;
            reg_addr <= slv_cmd_q[6:0];
            reg_wdata <= slv_wr_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // master command handling
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         mst_busy <= 1'b0;
         mst_done <= 1'b0;
         mst_go_q <= 1'b0;
         mst_keep_q <= 1'b0;
         mst_nb_q <= 6'h00;
         mst_wd_q <= 32'h00000000;
         mst_rdata <= 32'h00000000;
      end else begin
         mst_go_q <= 1'b0;
         mst_done <= 1'b0;
         if (!mst_busy && in_master && mst_start && mst_nbits != 6'h00) begin
            mst_busy <= 1'b1;
            mst_go_q <= 1'b1;
            mst_nb_q <= (mst_nbits > serial_port_pkg::WORD_BITS) ? serial_port_pkg::WORD_BITS
                                                               : mst_nbits;
            mst_wd_q <= mst_wdata;
            mst_keep_q <= mst_keep_select;
         end else if (mst_busy && !mst_go_q && eng_done) begin
            mst_busy <= 1'b0;
            mst_done <= 1'b1;
            mst_rdata <= eng_rdata;
         end else if (!mst_busy && !in_master) begin
            mst_keep_q <= 1'b0;
         end else if (!mst_busy && mst_start == 1'b0 && !mst_keep_select) begin
            mst_keep_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // boot sequencer: read command, then a fixed count of words
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         boot_st_q <= serial_port_pkg::BOOT_IDLE;
         boot_go_q <= 1'b0;
         boot_nb_q <= 6'h00;
         boot_wd_q <= 32'h00000000;
         boot_idx_q <= 16'h0000;
         boot_word <= 32'h00000000;
         boot_word_valid <= 1'b0;
         boot_done <= 1'b0;
      end else begin
         boot_go_q <= 1'b0;
         boot_word_valid <= 1'b0;
         case (boot_st_q)
            serial_port_pkg::BOOT_IDLE: begin
               if (in_boot && !boot_done) begin
                  boot_go_q <= 1'b1;
                  boot_nb_q <= serial_port_pkg::WORD_BITS;
                  boot_wd_q <= {serial_port_pkg::READ_CMD, serial_port_pkg::BOOT_ADDR};
                  boot_st_q <= serial_port_pkg::BOOT_CMD;
               end
            end
            serial_port_pkg::BOOT_CMD: begin
               if (eng_done && !boot_go_q) begin
                  boot_go_q <= 1'b1;
                  boot_wd_q <= 32'h00000000;
                  boot_idx_q <= 16'h0000;
                  boot_st_q <= serial_port_pkg::BOOT_DATA;
               end
            end
            serial_port_pkg::BOOT_DATA: begin
               if (eng_done && !boot_go_q) begin
                  boot_word <= eng_rdata;
                  boot_word_valid <= 1'b1;
                  boot_idx_q <= boot_idx_q + 16'h0001;
                  if (boot_idx_q == 16'(BOOT_WORDS - 1)) begin
                     boot_done <= 1'b1;
                     boot_st_q <= serial_port_pkg::BOOT_FIN;
                  end else begin
                     boot_go_q <= 1'b1;
                  end
               end
            end
            serial_port_pkg::BOOT_FIN: begin
               boot_st_q <= serial_port_pkg::BOOT_FIN;
            end
            default: begin
               boot_st_q <= serial_port_pkg::BOOT_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // select output for master and boot
   // ----------------------------------------------------------------
   // low from the accepted request until the access ends, or past its end while mst_keep_select was set with the request
   always_ff @(posedge clk) begin
      if (srst) begin
         serial_port_select_n_o <= 1'b1;
      end else if (in_boot) begin
         if (boot_st_q == serial_port_pkg::BOOT_FIN || boot_done) begin
            serial_port_select_n_o <= 1'b1;
         end else if (boot_go_q || boot_st_q != serial_port_pkg::BOOT_IDLE) begin
            serial_port_select_n_o <= 1'b0;
         end
      end else if (in_master) begin
         if (mst_go_q || (mst_busy && !eng_done)) begin
            serial_port_select_n_o <= 1'b0;
         end else if (!mst_keep_q || (mst_busy && eng_done && !mst_keep_q)) begin
            serial_port_select_n_o <= 1'b1;
         end
      end else begin
         serial_port_select_n_o <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // shared shift engine for master and boot
   // ----------------------------------------------------------------
   assign eng_start = in_boot ? boot_go_q : mst_go_q;
   assign eng_nbits = in_boot ? boot_nb_q : mst_nb_q;
   assign eng_wdata = in_boot ? boot_wd_q : mst_wd_q;
   assign eng_div = in_boot ? BOOT_DIV : mst_div;

   serial_shift_engine u_engine (
      .clk(clk),
      .srst(srst),
      .start(eng_start),
      .nbits(eng_nbits),
      .wdata(eng_wdata),
      .div(eng_div),
      .rdata(eng_rdata),
      .busy(),
      .done(eng_done),
      .miso(di_s),
      .sclk_q(eng_sclk),
      .mosi_q(eng_mosi)
   );

   // data-out mux picks between two flops, sclk_o is the engine flop alone; slave side always ahead of mode change
   assign sclk_o = eng_sclk;
   assign data_out_o = in_slave ? slv_do_q : eng_mosi;
   assign data_out_oe = in_slave ? slv_oe_q : 1'b1;

endmodule

// ==== testbench/serial_port_assertions.sv ====
// checker on the serial cpu port pins, master handshake and boot status
// assumes it is bound onto serial_cpu_port_mode_ctrl; all checks on clk
`timescale 1ns/1ps
module serial_port_checker (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pin directions and select
   input wire logic sclk_oe,
   input wire logic data_out_oe,
   input wire logic serial_port_select_n_i,
   input wire logic serial_port_select_n_o,
   input wire logic serial_port_select_n_oe,
   // status
   input wire serial_port_pkg::mode_t port_mode,
   input wire logic mst_busy,
   input wire logic mst_done,
   input wire logic boot_word_valid,
   input wire logic boot_done
);
   // ------------------------------
   // pin and handshake properties
   // ------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // slave mode held two cycles, so the pin mux has settled
   a_slave_pins_in: assert property (port_mode == serial_port_pkg::MODE_SLAVE &&
      $past(port_mode) == serial_port_pkg::MODE_SLAVE |-> !sclk_oe && !serial_port_select_n_oe)
      else $error("slave mode drives clock or select");
   a_slave_no_drive: assert property (port_mode == serial_port_pkg::MODE_SLAVE &&
      $past(port_mode) == serial_port_pkg::MODE_SLAVE && serial_port_select_n_i |-> !data_out_oe)
      else $error("data out driven while deselected");
   a_busy_drives: assert property (mst_busy |-> sclk_oe && data_out_oe)
      else $error("master access without driving pins");
   a_select_falls: assert property ($rose(mst_busy) |-> ##[0:2] !serial_port_select_n_o)
      else $error("select not low at access start");
   a_select_held: assert property (mst_busy && !serial_port_select_n_o |=>
      !serial_port_select_n_o || !mst_busy) else $error("select released mid access");
   a_done_pulse: assert property (mst_done |=> !mst_done && !mst_busy)
      else $error("done longer than one cycle");
   a_boot_select: assert property (boot_word_valid |-> !serial_port_select_n_o &&
      port_mode == serial_port_pkg::MODE_BOOT) else $error("boot word outside boot fetch");
   a_boot_release: assert property ($rose(boot_done) |-> ##[0:4] serial_port_select_n_o)
      else $error("select kept low after boot");
   a_boot_once: assert property ($past(boot_done) |-> port_mode != serial_port_pkg::MODE_BOOT)
      else $error("boot mode after boot done");
endmodule
bind serial_cpu_port_mode_ctrl serial_port_checker serial_port_checker_inst (.clk(clk),
   .srst(srst), .sclk_oe(sclk_oe), .data_out_oe(data_out_oe),
   .serial_port_select_n_i(serial_port_select_n_i),
   .serial_port_select_n_o(serial_port_select_n_o),
   .serial_port_select_n_oe(serial_port_select_n_oe), .port_mode(port_mode),
   .mst_busy(mst_busy), .mst_done(mst_done), .boot_word_valid(boot_word_valid),
   .boot_done(boot_done));

// ==== testbench/serial_mem_model.sv ====
// far-side model: serial memory in boot, slave device in master mode
// assumes clock idles low, select active low; replies a cyclic word
`timescale 1ns/1ps
module serial_mem_model #(
   parameter logic [31:0] PATTERN = 32'h5A3C_96E1
) (
   // pins
   input wire logic sclk,
   input wire logic select_n,
   input wire logic mosi,
   output logic miso,
   // observed traffic
   output logic [31:0] rx,
   output logic [31:0] cmd
);
   logic [4:0] idx_q;
   logic got_q;
   // change on rising clock so the device samples a steady bit on falling
   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         idx_q <= 5'h00;
         got_q <= 1'b0;
         miso <= 1'b1; // released line reads as pulled up
      end else begin
         miso <= PATTERN[5'h1F - idx_q];
         rx <= {rx[30:0], mosi};
         if (idx_q == 5'h1F && !got_q) begin
            cmd <= {rx[30:0], mosi};
            got_q <= 1'b1;
         end
         idx_q <= idx_q + 5'h01;
      end
   end
endmodule

// ==== testbench/serial_cpu_port_mode_ctrl_tb_top.sv ====
// self-checking bench: boot fetch, master accesses, slave frames
// assumes the checker is bound and the memory model sits on the pins
`timescale 1ns/1ps
module serial_cpu_port_mode_ctrl_tb_top;
   localparam logic [31:0] MEM_WORD = 32'h5A3C_96E1;
   localparam logic [31:0] REG_VAL = 32'hC3A5_1E0F;
   logic clk, srst, tb_sclk, tb_cs_n, tb_di, master_enable, mst_start;
   logic sclk_o, sclk_oe, data_out_o, data_out_oe, sel_o, sel_oe, miso;
   logic reg_we, reg_re, mst_busy, mst_done, boot_word_valid, boot_done;
   logic [5:0] mst_nbits;
   logic [6:0] reg_addr;
   logic [31:0] mst_wdata, mst_rdata, reg_wdata, boot_word, rx, cmd;
   serial_port_pkg::mode_t port_mode;
   int miscompares = 0;
   int checks_done = 0;
   // clock and select pins from the port's enables, data-in from the bench select; data-in is the memory model's miso while the bench select is high
   wire sclk_pin = sclk_oe ? sclk_o : tb_sclk;
   wire sel_pin = sel_oe ? sel_o : tb_cs_n;
   wire di_pin = tb_cs_n ? miso : tb_di;
   serial_cpu_port_mode_ctrl #(.BOOT_WORDS(4)) serial_cpu_port_mode_ctrl_inst (.clk(clk),
      .srst(srst), .slave_sclk(sclk_pin), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .serial_port_data_in(di_pin), .data_out_o(data_out_o), .data_out_oe(data_out_oe),
      .serial_port_select_n_i(sel_pin), .serial_port_select_n_o(sel_o),
      .serial_port_select_n_oe(sel_oe), .boot_config_straps(2'h1),
      .master_enable(master_enable), .port_mode(port_mode), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(REG_VAL),
      .mst_start(mst_start), .mst_nbits(mst_nbits), .mst_wdata(mst_wdata), .mst_div(8'h02),
      .mst_keep_select(1'b0), .mst_busy(mst_busy), .mst_done(mst_done),
      .mst_rdata(mst_rdata), .boot_word(boot_word), .boot_word_valid(boot_word_valid),
      .boot_done(boot_done));
   serial_mem_model #(.PATTERN(MEM_WORD)) serial_mem_model_inst (.sclk(sclk_pin),
      .select_n(sel_oe ? sel_o : 1'b1), .mosi(data_out_o), .miso(miso), .rx(rx), .cmd(cmd));
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // external master frame on the 12 ns link clock, msb first
   task automatic frame(input logic [47:0] f, input int len, output logic [31:0] got);
      tb_cs_n = 1'b0;
      #5;
      for (int i = 47; i >= 48 - len; i--) begin
         tb_di = f[i];
         #6 tb_sclk = 1'b1;
         got = {got[30:0], data_out_o};
         #6 tb_sclk = 1'b0;
      end
      #5 tb_cs_n = 1'b1;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_boot();
      int words = 0;
      for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) begin
         @(negedge clk);
         if (boot_word_valid === 1'b1) begin
            words++;
            check(boot_word, MEM_WORD);
         end
      end
      check(boot_done, 1'b1);
      check(words, 4);
      check(cmd, {serial_port_pkg::READ_CMD, serial_port_pkg::BOOT_ADDR});
      repeat (6) @(negedge clk);
      check(sel_pin, 1'b1);
      check(port_mode, serial_port_pkg::MODE_MASTER);
   endtask
   task automatic t_master(input logic [5:0] n, input logic [31:0] w);
      logic [31:0] mask = (32'h0000_0001 << n) - 32'h0000_0001;
      @(negedge clk);
      mst_nbits = n;
      mst_wdata = w;
      mst_start = 1'b1;
      @(negedge clk);
      mst_start = 1'b0;
      for (int i = 0; i < 600 && mst_done !== 1'b1; i++) @(negedge clk);
      check(mst_done, 1'b1);
      check(mst_rdata, MEM_WORD >> (32 - n));
      check(rx & mask, w & mask);
   endtask
   task automatic t_slave();
      logic [31:0] got;
      logic we_seen = 1'b0;
      master_enable = 1'b0;
      for (int i = 0; i < 50 && port_mode !== serial_port_pkg::MODE_SLAVE; i++) @(negedge clk);
      check(port_mode, serial_port_pkg::MODE_SLAVE);
      // pin roles follow the mode one cycle later
      @(negedge clk);
      check({sclk_oe, sel_oe}, 2'h0);
      // short write first: must be dropped, the full one must land
      frame({1'b1, 7'h11, 8'h00, 32'h0BAD_0BAD}, 40, got);
      for (int j = 0; j < 2; j++) begin
         repeat (10) begin
            @(negedge clk);
            if (reg_we === 1'b1) we_seen = 1'b1;
         end
         check(we_seen, j);
         if (j == 0) frame({1'b1, 7'h05, 8'h00, 32'h1234_ABCD}, 48, got);
      end
      check(reg_addr, 7'h05);
      check(reg_wdata, 32'h1234_ABCD);
      check(data_out_oe, 1'b0);
      frame({1'b0, 7'h09, 8'h00, 32'h0000_0000}, 48, got);
      check(got, REG_VAL);
      repeat (10) @(negedge clk);
      check(reg_addr, 7'h09);
   endtask
   // ------------------------------
   // clock, sequence and watchdog
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      {srst, tb_cs_n, tb_di, tb_sclk, master_enable, mst_start} = 6'h3A;
      mst_nbits = 6'h00;
      mst_wdata = 32'h0000_0000;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      t_boot();
      t_master(6'h08, 32'h0000_00A5);
      t_master(6'h20, 32'hC0DE_1234);
      t_slave();
      conclude();
   end
   // the whole run needs well under 5000 cycles; 25000 means a hang
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule
